// ---- logic/pin_reset_irq_logic.sv ----
// Pin-level reset, external interrupt and port direction control.
// Assumes pins arrive asynchronously; watchdog, illegal-address and
// programming-port signals come from logic on clk.
//
// How it works
// - While the reset pin is held low the block holds the core in reset.
// - A watchdog or illegal-address reset pulls the reset pin low itself.
// - A build option picks edge-only or edge-plus-level request sensing.
// - The request reaches the core without waiting for the divided clock.
// - With keyboard wake-up built in, port A lines 0-3 high also request.
// - The keyboard lines use the same edge or level sensing as the pin.
// - After any reset all port A lines are inputs, save in programming.
// - Port B line 0 is a software direction line, input after reset, save in programming.
// - Port B line 1 is input after reset, save programming or RC build.
// - With pulldowns built in, each port A pin has a software pulldown.
// - The operating clock is the input clock divided by two.
`timescale 1ns/1ps
module pin_reset_irq_logic #(
    parameter bit EDGE_AND_LEVEL = 1'b0,
    parameter bit KEYBOARD_EN = 1'b0,
    parameter bit PULLDOWN_EN = 1'b1,
    parameter bit RC_THREE_PIN = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Reset pin, open drain
    input wire logic resetPinInN,
    output logic resetPinOut,
    output logic resetPinOe,
    // Interrupt request pin and core side
    input wire logic requestPinN,
    input wire logic irqAck,
    output logic cpuIrq,
    output logic irqOut,
    // Internal reset causes and core reset
    input wire logic watchdogTimeout,
    input wire logic illegalAddress,
    output logic cpuReset,
    output logic opClockEnable,
    // Serial programming strap and its port drive
    input wire logic serialProgMode,
    input wire logic [9:0] progPortOut,
    input wire logic [9:0] progPortOe,
    // RC oscillator third terminal drive
    input wire logic rcDrive,
    // Port A and port B pins
    input wire logic [7:0] portAIn,
    output logic [7:0] portAOut,
    output logic [7:0] portAOe,
    output logic [7:0] portAPullEn,
    input wire logic [1:0] portBIn,
    output logic [1:0] portBOut,
    output logic [1:0] portBOe,
    output logic [1:0] portBPullEn
);
    typedef struct packed {
        logic opPhase;
        logic opEnable;
        logic [7:0] aData;
        logic [7:0] aDir;
        logic [7:0] aPull;
        logic [1:0] bData;
        logic [1:0] bDir;
        logic [1:0] bPull;
        logic [2:0] status;
        logic [2:0] mask;
        logic reqPrev;
        logic irqPending;
        pin_irq_pkg::pulldown_t pd;
        logic [2:0] pullCount;
        logic coreReset;
        logic [7:0] aOut;
        logic [7:0] aOe;
        logic [7:0] aPullEn;
        logic [1:0] bOut;
        logic [1:0] bOe;
        logic [1:0] bPullEn;
        logic pinOe;
        logic irqLine;
        logic coreIrq;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awRdy;
        logic wRdy;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } state_t;

    state_t cur;
    state_t next_cur;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [12:0] pinSync;
    logic [7:0] portASync;
    logic [1:0] portBSync;
    logic requestSyncN;
    logic resetSyncN;
    logic progSync;

    bit_sync #(.W(13)) pinSyncInst (
        .clk(clk),
        .rst_n(rst_n),
        .d({serialProgMode, resetPinInN, ~requestPinN, portBIn, portAIn}),
        .q(pinSync)
    );

    assign portASync = pinSync[7:0];
    assign portBSync = pinSync[9:8];
    assign requestSyncN = !pinSync[10]; // Stored inverted: reset reads idle
    assign resetSyncN = pinSync[11];
    assign progSync = pinSync[12];

    // ----------------------------------------
    // Combined request source
    // ----------------------------------------
    logic keyActive;
    logic reqNow;
    logic reqEdge;

    // Keyboard lines are active high, the pin active low
    assign keyActive = KEYBOARD_EN && (|portASync[3:0]);
    assign reqNow = !requestSyncN || keyActive;
    assign reqEdge = reqNow && !cur.reqPrev;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [2:0] setNow;
        logic doWrite;
        logic [7:0] lane;
        logic [31:0] rd;
        logic rdHit;
        logic [2:0] rdClear;
        logic trigger;
        setNow = 3'h0;
        doWrite = 1'b0;
        lane = 8'h00;
        rd = 32'h0;
        rdHit = 1'b1;
        rdClear = 3'h0;
        trigger = 1'b0;
        next_cur = cur;

        // Divide by two for the operating clock enable
        next_cur.opPhase = !cur.opPhase;
        next_cur.opEnable = cur.opPhase;

        // Edge always triggers; level only when built for it
        trigger = reqEdge || (EDGE_AND_LEVEL && reqNow);
        next_cur.reqPrev = reqNow;
        setNow[pin_irq_pkg::ST_EXT] = trigger;
        setNow[pin_irq_pkg::ST_WDOG] = watchdogTimeout;
        setNow[pin_irq_pkg::ST_ILADR] = illegalAddress;

        // Pending edge holds until the core acknowledges; set wins
        if (irqAck) begin
            next_cur.irqPending = 1'b0;
        end
        if (reqEdge) begin
            next_cur.irqPending = 1'b1;
        end
        // Not gated by opEnable, so no alignment to the core clock
        next_cur.coreIrq = next_cur.irqPending
            || (EDGE_AND_LEVEL && reqNow);

        // Reset pin pulldown sequence
        unique case (cur.pd)
            pin_irq_pkg::PD_IDLE: begin
                if (watchdogTimeout || illegalAddress) begin
                    next_cur.pd = pin_irq_pkg::PD_PULL;
                    next_cur.pullCount =
                        3'(pin_irq_pkg::PULL_OP_CYCLES - 1);
                end
            end
            pin_irq_pkg::PD_PULL: begin
                if (cur.opEnable) begin
                    if (cur.pullCount == 3'h0) begin
                        next_cur.pd = pin_irq_pkg::PD_WAIT;
                    end else begin
                        next_cur.pullCount = cur.pullCount - 3'h1;
                    end
                end
            end
            pin_irq_pkg::PD_WAIT: begin
                // Board RC may hold the pin low a while longer
                if (resetSyncN) begin
                    next_cur.pd = pin_irq_pkg::PD_IDLE;
                end
            end
            default: begin
                next_cur.pd = pin_irq_pkg::PD_IDLE;
            end
        endcase
        next_cur.pinOe = (next_cur.pd == pin_irq_pkg::PD_PULL);
        next_cur.coreReset = !resetSyncN
            || (next_cur.pd != pin_irq_pkg::PD_IDLE);

        // AXI write channel capture, either order
        if (awvalid && cur.awRdy) begin
            next_cur.awHeld = 1'b1;
            next_cur.awAddr = awaddr;
        end
        if (wvalid && cur.wRdy) begin
            next_cur.wHeld = 1'b1;
            next_cur.wData = wdata;
            next_cur.wStrb = wstrb;
        end
        if (bready && cur.bValid) begin
            next_cur.bValid = 1'b0;
        end
        if (cur.awHeld && cur.wHeld && !cur.bValid) begin
            doWrite = cur.wStrb[0];
            lane = cur.wData[7:0];
            next_cur.awHeld = 1'b0;
            next_cur.wHeld = 1'b0;
            next_cur.bValid = 1'b1;
            next_cur.bResp = pin_irq_pkg::RESP_OKAY;
            unique case (cur.awAddr)
                pin_irq_pkg::PORTA_DATA_OFS: begin
                    if (doWrite) next_cur.aData = lane;
                end
                pin_irq_pkg::PORTA_DIR_OFS: begin
                    if (doWrite) next_cur.aDir = lane;
                end
                pin_irq_pkg::PORTA_PULL_OFS: begin
                    // Pulldown storage exists only when built in
                    if (doWrite && PULLDOWN_EN) begin
                        next_cur.aPull = lane;
                    end
                end
                pin_irq_pkg::PORTB_CTRL_OFS: begin
                    if (doWrite) begin
                        next_cur.bData = lane[pin_irq_pkg::PB_DATA_LSB +: 2];
                        next_cur.bDir = lane[pin_irq_pkg::PB_DIR_LSB +: 2];
                        if (PULLDOWN_EN) begin
                            next_cur.bPull =
                                lane[pin_irq_pkg::PB_PULL_LSB +: 2];
                        end
                    end
                end
                pin_irq_pkg::IRQ_MASK_OFS: begin
                    if (doWrite) next_cur.mask = lane[2:0];
                end
                pin_irq_pkg::PIN_STATE_OFS,
                pin_irq_pkg::IRQ_STATUS_OFS: begin
                    // Read-only: accepted and discarded
                end
                default: begin
                    next_cur.bResp = pin_irq_pkg::RESP_SLVERR;
                end
            endcase
        end

        // AXI read channel
        if (rready && cur.rValid) begin
            next_cur.rValid = 1'b0;
        end
        if (arvalid && cur.arRdy) begin
            unique case (araddr)
                pin_irq_pkg::PORTA_DATA_OFS: rd = {24'h0, cur.aData};
                pin_irq_pkg::PORTA_DIR_OFS: rd = {24'h0, cur.aDir};
                pin_irq_pkg::PORTA_PULL_OFS: rd = {24'h0, cur.aPull};
                pin_irq_pkg::PORTB_CTRL_OFS:
                    rd = {26'h0, cur.bPull, cur.bDir, cur.bData};
                pin_irq_pkg::PIN_STATE_OFS:
                    rd = {19'h0, progSync, resetSyncN, requestSyncN,
                          portBSync, portASync};
                pin_irq_pkg::IRQ_STATUS_OFS: begin
                    rd = {29'h0, cur.status};
                    rdClear = cur.status;
                end
                pin_irq_pkg::IRQ_MASK_OFS: rd = {29'h0, cur.mask};
                default: rdHit = 1'b0;
            endcase
            next_cur.rValid = 1'b1;
            next_cur.rData = rd;
            next_cur.rResp = rdHit ? pin_irq_pkg::RESP_OKAY
                                   : pin_irq_pkg::RESP_SLVERR;
        end
        // Clear on read, but a new event in the same cycle survives
        next_cur.status = (cur.status & ~rdClear) | setNow;
        next_cur.irqLine = |(next_cur.status & next_cur.mask);

        // Any reset returns the port direction registers to inputs
        if (cur.coreReset) begin
            next_cur.aDir = pin_irq_pkg::PORTA_RESET;
            next_cur.bDir = pin_irq_pkg::PORTB_RESET;
        end

        // Pin drive; programming mode overrides the registers
        next_cur.aOut = next_cur.aData;
        next_cur.aOe = next_cur.aDir;
        next_cur.bOut = next_cur.bData;
        next_cur.bOe = next_cur.bDir;
        if (progSync) begin
            next_cur.aOut = progPortOut[7:0];
            next_cur.aOe = progPortOe[7:0];
            next_cur.bOut = progPortOut[9:8];
            next_cur.bOe = progPortOe[9:8];
        end
        if (RC_THREE_PIN) begin
            // Third oscillator terminal owns line one
            next_cur.bOut[1] = rcDrive;
            next_cur.bOe[1] = 1'b1;
        end
        // A pulldown is pointless on a line the block drives
        next_cur.aPullEn = next_cur.aPull & ~next_cur.aOe;
        next_cur.bPullEn = next_cur.bPull & ~next_cur.bOe;

        // One transaction of each kind in flight
        next_cur.awRdy = !next_cur.awHeld && !next_cur.bValid;
        next_cur.wRdy = !next_cur.wHeld && !next_cur.bValid;
        next_cur.arRdy = !next_cur.rValid;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.pd <= pin_irq_pkg::PD_IDLE;
            cur.mask <= pin_irq_pkg::MASK_RESET;
            cur.coreReset <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register; the reset pin data is tied low
    assign awready = cur.awRdy;
    assign wready = cur.wRdy;
    assign bvalid = cur.bValid;
    assign bresp = cur.bResp;
    assign arready = cur.arRdy;
    assign rvalid = cur.rValid;
    assign rdata = cur.rData;
    assign rresp = cur.rResp;
    assign resetPinOut = 1'b0;
    assign resetPinOe = cur.pinOe;
    assign cpuIrq = cur.coreIrq;
    assign irqOut = cur.irqLine;
    assign cpuReset = cur.coreReset;
    assign opClockEnable = cur.opEnable;
    assign portAOut = cur.aOut;
    assign portAOe = cur.aOe;
    assign portAPullEn = cur.aPullEn;
    assign portBOut = cur.bOut;
    assign portBOe = cur.bOe;
    assign portBPullEn = cur.bPullEn;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence pullStart;
        (cur.pd == pin_irq_pkg::PD_IDLE)
            && (watchdogTimeout || illegalAddress);
    endsequence

    sequence pullHeld;
        resetPinOe [*7];
    endsequence

    pull_start_a: assert property (pullStart |=> resetPinOe && cpuReset)
        else $error("reset pin not pulled after internal reset");
    pull_len_a: assert property (pullStart |=> pullHeld)
        else $error("reset pin pulldown too short");
    startup_hold_a: assert property (!resetSyncN |=> cpuReset)
        else $error("core not held in reset while pin low");
    porta_input_a: assert property (
        cpuReset && !progSync |=> portAOe == 8'h00)
        else $error("port A not input after reset");
    portb_zero_a: assert property (
        cpuReset && !progSync |=> !portBOe[0])
        else $error("port B line 0 not input after reset");
    portb_one_a: assert property (
        cpuReset && !progSync |=> portBOe[1] == RC_THREE_PIN)
        else $error("port B line 1 direction wrong after reset");
    edge_irq_a: assert property (reqEdge |=> cpuIrq [*2])
        else $error("edge request not held for the core");
    level_hold_a: assert property (
        EDGE_AND_LEVEL && reqNow |=> cpuIrq)
        else $error("level request dropped while active");
    key_wake_a: assert property (
        KEYBOARD_EN && requestSyncN && $rose(|portASync[3:0])
        |=> cpuIrq)
        else $error("keyboard line did not request");
    pulldown_opt_a: assert property (
        !PULLDOWN_EN |-> portAPullEn == 8'h00)
        else $error("pulldown active when not built in");
    op_divide_a: assert property (
        opClockEnable |=> !opClockEnable ##1 opClockEnable)
        else $error("operating clock enable not divided by two");
    irq_line_a: assert property (
        $rose(|(cur.status & cur.mask)) |-> irqOut ##1 irqOut)
        else $error("interrupt output missed unmasked status");
    write_resp_a: assert property (
        cur.awHeld && cur.wHeld && !bvalid |=> bvalid)
        else $error("write response late");
endmodule // pin_reset_irq_logic

// ---- logic/pin_irq_pkg.sv ----
// Constants shared by the pin, reset and interrupt control block.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
package pin_irq_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] PORTA_DATA_OFS = 8'h00;
    localparam logic [7:0] PORTA_DIR_OFS = 8'h04;
    localparam logic [7:0] PORTA_PULL_OFS = 8'h08;
    localparam logic [7:0] PORTB_CTRL_OFS = 8'h0C;
    localparam logic [7:0] PIN_STATE_OFS = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h18;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PB_DATA_LSB = 0;
    localparam int PB_DIR_LSB = 2;
    localparam int PB_PULL_LSB = 4;
    localparam int ST_EXT = 0;
    localparam int ST_WDOG = 1;
    localparam int ST_ILADR = 2;

    // ----------------------------------------
    // Reset values and bus answers
    // ----------------------------------------
    localparam logic [7:0] PORTA_RESET = 8'h00;
    localparam logic [1:0] PORTB_RESET = 2'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int OP_DIVIDE = 2;
    localparam int PULL_TIME_NS = 32;
    localparam int PULL_OP_CYCLES =
        PULL_TIME_NS / (CLK_PERIOD_NS * OP_DIVIDE);

    // Reset pin pulldown sequencer; one bit flips per step, save WAIT back to IDLE
    typedef enum logic [1:0] {
        PD_IDLE = 2'h0,
        PD_PULL = 2'h1,
        PD_WAIT = 2'h3
    } pulldown_t;

endpackage

// ---- logic/bit_sync.sv ----
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_t;

    sync_t cur;
    sync_t next_cur;

    // First stage feeds only the second
    always_comb begin
        next_cur.meta = d;
        next_cur.stable = cur.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign q = cur.stable;
endmodule // bit_sync

// ---- sim/board_model.sv ----
// Board side of the block: pulled-up reset and request pins, keypad.
// Assumes the block drives a pin only while its enable is high.
`timescale 1ns/1ps
module board_model (
    input wire logic clk,
    input wire logic resetBtnN,
    input wire logic irqBtnN,
    input wire logic [3:0] keys,
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    input wire logic [7:0] portAOut,
    input wire logic [7:0] portAOe,
    input wire logic [7:0] portAPullEn,
    input wire logic [1:0] portBOut,
    input wire logic [1:0] portBOe,
    output logic resetPinInN,
    output logic requestPinN,
    output logic [7:0] portAIn,
    output logic [1:0] portBIn
);
    logic toggle = 1'b0;

    // Undriven port B lines and unpulled port A lines 4-7 wander each cycle so a stale value never looks right
    always @(posedge clk) begin
        toggle <= ~toggle;
    end

    // Pull-ups on both pins; any low driver wins the wire
    assign resetPinInN = resetBtnN & ~(resetPinOe & ~resetPinOut);
    assign requestPinN = irqBtnN;

    // Keypad lines carry board pulldowns, so idle keys read low
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (portAOe[i])
                portAIn[i] = portAOut[i];
            else if (i < 4)
                portAIn[i] = keys[i];
            else
                portAIn[i] = portAPullEn[i] ? 1'b0 : toggle;
        end
        for (int i = 0; i < 2; i++) begin
            portBIn[i] = portBOe[i] ? portBOut[i] : toggle;
        end
    end
endmodule // board_model

// ---- sim/pin_reset_irq_logic_tb.sv ----
// Self-checking bench for the pin, reset and interrupt block.
// Assumes the board model on the pins and AXI4-Lite timing of the notes.
`timescale 1ns/1ps
module pin_reset_irq_logic_tb;
    logic clk = 1'b0;
    logic rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
    logic arready, rvalid, rready, resetPinInN, resetPinOut, resetPinOe;
    logic requestPinN, irqAck, cpuIrq, irqOut, watchdogTimeout, rcDrive;
    logic illegalAddress, cpuReset, opClockEnable, serialProgMode;
    logic resetBtnN, irqBtnN;
    logic [7:0] awaddr, araddr, portAIn, portAOut, portAOe, portAPullEn;
    logic [31:0] wdata, rdata, v, pa;
    logic [3:0] wstrb, keys;
    logic [1:0] bresp, rresp, portBIn, portBOut, portBOe, portBPullEn;
    logic [9:0] progPortOut, progPortOe;
    logic [67:0] expQ[$];
    logic [67:0] e;
    int failures = 0, comparisons = 0, seed = 68, cycles = 0, n;

    // Level and keyboard options built in to reach the most logic
    pin_reset_irq_logic #(.EDGE_AND_LEVEL(1'b1), .KEYBOARD_EN(1'b1),
        .PULLDOWN_EN(1'b1), .RC_THREE_PIN(1'b0)) pin_reset_irq_logic_i (
        .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .resetPinInN(resetPinInN), .resetPinOut(resetPinOut),
        .resetPinOe(resetPinOe), .requestPinN(requestPinN),
        .irqAck(irqAck), .cpuIrq(cpuIrq), .irqOut(irqOut),
        .watchdogTimeout(watchdogTimeout), .illegalAddress(illegalAddress),
        .cpuReset(cpuReset), .opClockEnable(opClockEnable),
        .serialProgMode(serialProgMode), .progPortOut(progPortOut),
        .progPortOe(progPortOe), .rcDrive(rcDrive), .portAIn(portAIn),
        .portAOut(portAOut), .portAOe(portAOe), .portAPullEn(portAPullEn),
        .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
        .portBPullEn(portBPullEn));

    board_model board_model_i (.clk(clk), .resetBtnN(resetBtnN),
        .irqBtnN(irqBtnN), .keys(keys), .resetPinOut(resetPinOut),
        .resetPinOe(resetPinOe), .portAOut(portAOut), .portAOe(portAOe),
        .portAPullEn(portAPullEn), .portBOut(portBOut),
        .portBOe(portBOe), .resetPinInN(resetPinInN),
        .requestPinN(requestPinN), .portAIn(portAIn), .portBIn(portBIn));

    always #2 clk = ~clk;
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [33:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Both write channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check("bresp", bresp, r);
    endtask

    // Expected word noted first; the monitor compares when it arrives
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r, input logic [33:0] m);
        expQ.push_back({m, r, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic ack;
        @(posedge clk);
        irqAck <= 1'b1;
        @(posedge clk);
        irqAck <= 1'b0;
        tick(2);
    endtask

    // Read monitor: oldest note against each completed read
    always @(posedge clk) begin
        if (rvalid && rready && expQ.size() > 0) begin
            e = expQ.pop_front();
            check("rdata", {rresp, rdata} & e[67:34], e[33:0]);
        end
    end

    // Hang guard, far above the cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, irqAck} = 6'h00;
        {watchdogTimeout, illegalAddress, serialProgMode, rcDrive} = 4'h0;
        {awaddr, araddr, wdata, wstrb, keys} = 56'h00000000_000F_0;
        {resetBtnN, irqBtnN, progPortOut, progPortOe} = 22'h300000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        tick(4);
        rd(pin_irq_pkg::IRQ_STATUS_OFS, 32'h0, 2'h0, '1);
        rd(pin_irq_pkg::PORTA_DIR_OFS, 32'h0, 2'h0, '1);
        rd(pin_irq_pkg::PORTB_CTRL_OFS, 32'h0, 2'h0, '1);
        v = $random(seed);
        pa = $random(seed);
        wr(pin_irq_pkg::PORTA_DIR_OFS, {24'h0, v[7:0]}, 2'h0);
        wr(pin_irq_pkg::PORTA_PULL_OFS, {24'h0, pa[7:0]}, 2'h0);
        wr(pin_irq_pkg::PORTB_CTRL_OFS, 32'h34, 2'h0);
        wr(8'h40, 32'h0, pin_irq_pkg::RESP_SLVERR);
        rd(8'h40, 32'h0, pin_irq_pkg::RESP_SLVERR, '1);
        rd(pin_irq_pkg::PORTA_DIR_OFS, {24'h0, v[7:0]}, 2'h0, '1);
        tick(1);
        check("portAOe", portAOe, v[7:0]);
        check("portAPull", portAPullEn, pa[7:0] & ~v[7:0]);
        check("portBOe", {portBPullEn, portBOe}, 4'h9);
        $display("test registers done");
        // Watchdog, then illegal address, each pulls the pin and resets
        for (int c = 0; c < 2; c++) begin
            @(posedge clk);
            watchdogTimeout <= (c == 0);
            illegalAddress <= (c == 1);
            @(posedge clk);
            watchdogTimeout <= 1'b0;
            illegalAddress <= 1'b0;
            #1;
            check("pullOe", resetPinOe, 1'b1);
            check("coreReset", cpuReset, 1'b1);
            n = 0;
            while (resetPinOe && n < 50) begin
                tick(1);
                n++;
            end
            check("pullLen", n inside {7, 8}, 1'b1);
            tick(6);
            check("coreRun", cpuReset, 1'b0);
            check("dirClear", {portBOe, portAOe}, 10'h0);
            rd(pin_irq_pkg::IRQ_STATUS_OFS, 32'h2 << c, 2'h0, 34'h6);
        end
        $display("test internal reset done");
        @(posedge clk);
        resetBtnN <= 1'b0;
        tick(4);
        check("pinReset", cpuReset, 1'b1);
        @(posedge clk);
        resetBtnN <= 1'b1;
        tick(5);
        check("pinRelease", cpuReset, 1'b0);
        n = 0;
        repeat (20) begin
            tick(1);
            n += opClockEnable;
        end
        check("opPulses", n, 10);
        $display("test pin reset and clock done");
        wr(pin_irq_pkg::IRQ_MASK_OFS, 32'h1, 2'h0);
        rd(pin_irq_pkg::IRQ_STATUS_OFS, 32'h0, 2'h0, '1);
        @(posedge clk);
        irqBtnN <= 1'b0;
        tick(4);
        check("irqFall", {cpuIrq, irqOut}, 2'h3);
        ack();
        check("irqLevel", cpuIrq, 1'b1);
        @(posedge clk);
        irqBtnN <= 1'b1;
        tick(4);
        ack();
        check("irqGone", cpuIrq, 1'b0);
        rd(pin_irq_pkg::IRQ_STATUS_OFS, 32'h1, 2'h0, '1);
        tick(2);
        check("irqOutClr", irqOut, 1'b0);
        // Each keyboard line requests on a high level
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            keys <= 4'h1 << i;
            tick(4);
            check("keyIrq", cpuIrq, 1'b1);
            @(posedge clk);
            keys <= 4'h0;
            tick(4);
            ack();
            check("keyIdle", cpuIrq, 1'b0);
        end
        $display("test interrupt done");
        v = $random(seed);
        @(posedge clk);
        serialProgMode <= 1'b1;
        progPortOe <= v[9:0];
        progPortOut <= v[19:10];
        tick(5);
        check("progOe", {portBOe, portAOe}, v[9:0]);
        check("progOut", {portBOut, portAOut}, v[19:10]);
        @(posedge clk);
        serialProgMode <= 1'b0;
        tick(5);
        $display("test programming mode done");
        end_sim();
    end
endmodule // pin_reset_irq_logic_tb
